// ==== fbparm_regs.sv ====
// frame-buffer parameter registers of the serial interface unit
// assumes: core special function register strobes, synchronous to MCLK
//Function
//- Manual-response transmit inserts the tx control byte.
//- Manual mode does not use or advance sequence counters.
//- Received information field is stored from rx buffer start.
//- Rx buffer length bounds the stored field; zero is valid.
//- Rx field length is loaded with the stored count; zero valid.
//- Rx control byte is loaded with the received control field.
//- Rx control byte is read-only to software.
//- A readable state counter shows the internal unit state.
//- Buffers starting at or below 191 never wrap; reaching RAM address 191 ends them.
//- Software sets rx-empty; device clears it on frame received.
//- Software sets tx-full; device clears it when sent.
`timescale 1ns/100ps
`include "fbparm_defs.svh"
module fbparm_regs (
    // clock and reset
    input  wire logic       MCLK,
    input  wire logic       SRST,
    // special function register access
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    // handshake flags
    input  wire logic       RBE_SET,
    input  wire logic       TBF_SET,
    output logic            RX_BUFFER_EMPTY_FLAG,
    output logic            TX_BUFFER_FULL_FLAG,
    // serial engine
    input  wire logic       MANUAL_MODE,
    input  wire logic       RX_BYTE_VALID,
    input  wire logic [7:0] RX_BYTE,
    input  wire logic       RX_FRAME_END,
    input  wire logic       TX_CTRL_REQ,
    input  wire logic       TX_FRAME_DONE,
    output logic      [7:0] TX_CTRL_FIELD,
    output logic            SEQ_ADVANCE,
    // on-chip ram write port
    output logic            RAM_WE,
    output logic      [7:0] RAM_ADDR,
    output logic      [7:0] RAM_WDATA
);
    typedef struct packed {
        logic [7:0] tx_control_byte;
        logic [7:0] rx_buffer_start;
        logic [7:0] rx_buffer_length;
        logic [7:0] rx_field_length;
        logic [7:0] rx_control_byte;
        logic       rx_buffer_empty_flag;
        logic       tx_buffer_full_flag;
        logic [7:0] rdata;
        logic [7:0] tx_field;
    } regs_t;
    regs_t r, next_r;

    logic       fill_done;
    logic [7:0] fill_count;
    logic [7:0] fill_ctrl;
    logic [2:0] fill_state;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    rx_fill u_fill (
        .clk        (MCLK),
        .rst        (SRST),
        .enable     (r.rx_buffer_empty_flag),
        .manual     (MANUAL_MODE),
        .start      (r.rx_buffer_start),
        .length     (r.rx_buffer_length),
        .byte_valid (RX_BYTE_VALID),
        .byte_data  (RX_BYTE),
        .frame_end  (RX_FRAME_END),
        .ram_we     (RAM_WE),
        .ram_addr   (RAM_ADDR),
        .ram_wdata  (RAM_WDATA),
        .done       (fill_done),
        .count      (fill_count),
        .ctrl       (fill_ctrl),
        .state_code (fill_state),
        .seq_advance(SEQ_ADVANCE)
    );

    always_comb begin
        next_r = r;
        if (SFR_WR) begin
            if (hit(SFR_ADDR, `OFS_TX_CONTROL_BYTE))
                next_r.tx_control_byte = SFR_WDATA;
            if (hit(SFR_ADDR, `OFS_RX_BUFFER_START))
                next_r.rx_buffer_start = SFR_WDATA;
            if (hit(SFR_ADDR, `OFS_RX_BUFFER_LENGTH))
                next_r.rx_buffer_length = SFR_WDATA;
            if (hit(SFR_ADDR, `OFS_RX_FIELD_LENGTH))
                next_r.rx_field_length = SFR_WDATA;
            // rx control byte and state counter ignore writes
        end
        if (RBE_SET) next_r.rx_buffer_empty_flag = 1'b1;
        if (TBF_SET) next_r.tx_buffer_full_flag = 1'b1;
        if (fill_done) begin
            // results land in the same edge the flag drops
            next_r.rx_field_length = fill_count;
            next_r.rx_control_byte = fill_ctrl;
            next_r.rx_buffer_empty_flag = 1'b0;
        end
        if (TX_FRAME_DONE) next_r.tx_buffer_full_flag = 1'b0;
        if (TX_CTRL_REQ && MANUAL_MODE)
            next_r.tx_field = r.tx_control_byte;
        next_r.rdata = 8'h00;
        if (SFR_RD) begin
            case (SFR_ADDR)
                `OFS_TX_CONTROL_BYTE:  next_r.rdata = r.tx_control_byte;
                `OFS_RX_BUFFER_START:  next_r.rdata = r.rx_buffer_start;
                `OFS_RX_BUFFER_LENGTH: next_r.rdata = r.rx_buffer_length;
                `OFS_RX_FIELD_LENGTH:  next_r.rdata = r.rx_field_length;
                `OFS_RX_CONTROL_BYTE:  next_r.rdata = r.rx_control_byte;
                `OFS_SERIAL_STATE_COUNTER:
                    next_r.rdata = {5'h00, fill_state};
                default:               next_r.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign SFR_RDATA = r.rdata;
    assign RX_BUFFER_EMPTY_FLAG = r.rx_buffer_empty_flag;
    assign TX_BUFFER_FULL_FLAG = r.tx_buffer_full_flag;
    assign TX_CTRL_FIELD = r.tx_field;

    a_rcb_readonly: assert property (@(posedge MCLK)
        disable iff (SRST)
        !$past(fill_done) |-> $stable(r.rx_control_byte))
        else $error("rx control byte changed without a frame");

    a_rbe_clears: assert property (@(posedge MCLK)
        disable iff (SRST)
        fill_done |=> !RX_BUFFER_EMPTY_FLAG)
        else $error("rx-empty not cleared after frame");

    a_rfl_loaded: assert property (@(posedge MCLK)
        disable iff (SRST)
        fill_done |=> r.rx_field_length == $past(fill_count))
        else $error("field length not loaded");

    a_tbf_clears: assert property (@(posedge MCLK)
        disable iff (SRST)
        TX_FRAME_DONE |=> !TX_BUFFER_FULL_FLAG)
        else $error("tx-full not cleared");

    a_tx_ctrl: assert property (@(posedge MCLK)
        disable iff (SRST)
        TX_CTRL_REQ && MANUAL_MODE |=>
            TX_CTRL_FIELD == $past(r.tx_control_byte))
        else $error("tx control field wrong");

    a_no_seq: assert property (@(posedge MCLK)
        disable iff (SRST)
        MANUAL_MODE && $past(MANUAL_MODE) |-> !SEQ_ADVANCE)
        else $error("sequence advanced in manual mode");

    a_ram_limit: assert property (@(posedge MCLK)
        disable iff (SRST)
        RAM_WE |-> RAM_ADDR >= r.rx_buffer_start
            && (RAM_ADDR <= `RAM_LAST_ADDR
                || r.rx_buffer_start > `RAM_LAST_ADDR))
        else $error("ram write outside receive buffer");

    a_ram_start: assert property (@(posedge MCLK)
        disable iff (SRST)
        RAM_WE && fill_count == 8'h01 |-> RAM_ADDR == r.rx_buffer_start)
        else $error("first field byte not at buffer start");

    a_rcb_loaded: assert property (@(posedge MCLK)
        disable iff (SRST)
        fill_done |=> r.rx_control_byte == $past(fill_ctrl))
        else $error("rx control byte not loaded");

    a_rbe_order: assert property (@(posedge MCLK)
        disable iff (SRST)
        $fell(RX_BUFFER_EMPTY_FLAG) |-> $past(fill_done)
            && r.rx_field_length == $past(fill_count)
            && r.rx_control_byte == $past(fill_ctrl))
        else $error("rx-empty dropped before results loaded");

    a_rbe_set: assert property (@(posedge MCLK)
        disable iff (SRST)
        RBE_SET && !fill_done |=> RX_BUFFER_EMPTY_FLAG)
        else $error("rx-empty not set by software");

    a_tbf_set: assert property (@(posedge MCLK)
        disable iff (SRST)
        TBF_SET && !TX_FRAME_DONE |=> TX_BUFFER_FULL_FLAG)
        else $error("tx-full not set by software");

    a_state_read: assert property (@(posedge MCLK)
        disable iff (SRST)
        SFR_RD && SFR_ADDR == `OFS_SERIAL_STATE_COUNTER |=>
            SFR_RDATA == {5'h00, $past(fill_state)})
        else $error("state counter read wrong");

    a_rcb_read: assert property (@(posedge MCLK)
        disable iff (SRST)
        SFR_RD && SFR_ADDR == `OFS_RX_CONTROL_BYTE |=>
            SFR_RDATA == $past(r.rx_control_byte))
        else $error("rx control byte read wrong");

    a_tcb_write: assert property (@(posedge MCLK)
        disable iff (SRST)
        SFR_WR && SFR_ADDR == `OFS_TX_CONTROL_BYTE |=>
            r.tx_control_byte == $past(SFR_WDATA))
        else $error("tx control byte write lost");

    a_rbs_write: assert property (@(posedge MCLK)
        disable iff (SRST)
        SFR_WR && SFR_ADDR == `OFS_RX_BUFFER_START |=>
            r.rx_buffer_start == $past(SFR_WDATA))
        else $error("rx buffer start write lost");

    a_rbl_write: assert property (@(posedge MCLK)
        disable iff (SRST)
        SFR_WR && SFR_ADDR == `OFS_RX_BUFFER_LENGTH |=>
            r.rx_buffer_length == $past(SFR_WDATA))
        else $error("rx buffer length write lost");
endmodule : fbparm_regs

// ==== fbparm_defs.svh ====
// frame-buffer parameter register offsets, reset values and limits
// assumes: byte-wide special function register space of the core
`ifndef FBPARM_DEFS_SVH
`define FBPARM_DEFS_SVH
`define OFS_RX_CONTROL_BYTE      8'hCA
`define OFS_RX_BUFFER_LENGTH     8'hCB
`define OFS_RX_BUFFER_START      8'hCC
`define OFS_RX_FIELD_LENGTH      8'hCD
`define OFS_SERIAL_STATE_COUNTER 8'hD9
`define OFS_TX_CONTROL_BYTE      8'hDA
`define REG_RESET                8'h00
`define RAM_LAST_ADDR            8'hBF
`endif

// ==== fbparm_pkg.sv ====
// types shared by the frame-buffer parameter block
// assumes: nothing beyond the defs header
package fbparm_pkg;
    typedef enum logic [2:0] {
        RX_IDLE, RX_CTRL, RX_DATA, RX_DONE
    } rx_state_t;
endpackage : fbparm_pkg

// ==== rx_fill.sv ====
// receive fill engine: writes the information field into on-chip RAM
// assumes: serial engine presents one byte per strobe, frame end strobe
`timescale 1ns/100ps
`include "fbparm_defs.svh"
module rx_fill (
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       enable,
    input  wire logic       manual,
    input  wire logic [7:0] start,
    input  wire logic [7:0] length,
    // serial engine side
    input  wire logic       byte_valid,
    input  wire logic [7:0] byte_data,
    input  wire logic       frame_end,
    // ram port
    output logic            ram_we,
    output logic      [7:0] ram_addr,
    output logic      [7:0] ram_wdata,
    // results
    output logic            done,
    output logic      [7:0] count,
    output logic      [7:0] ctrl,
    output logic      [2:0] state_code,
    output logic            seq_advance
);
    typedef struct packed {
        fbparm_pkg::rx_state_t st;
        logic [7:0] addr;
        logic [7:0] cnt;
        logic [7:0] ctl;
        logic       we;
        logic [7:0] wd;
        logic       done;
        logic       stop;
        logic       adv;
    } fill_t;
    fill_t cur, next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.we = 1'b0;
        next_cur.done = 1'b0;
        next_cur.adv = 1'b0;
        case (cur.st)
            fbparm_pkg::RX_IDLE: begin
                next_cur.addr = start;
                next_cur.cnt = 8'h00;
                next_cur.stop = 1'b0;
                // flag still high while done stands: no re-arm
                if (enable && !cur.done) next_cur.st = fbparm_pkg::RX_CTRL;
            end
            fbparm_pkg::RX_CTRL: begin
                if (byte_valid) begin
                    next_cur.ctl = byte_data;
                    next_cur.st = fbparm_pkg::RX_DATA;
                end
            end
            fbparm_pkg::RX_DATA: begin
                if (frame_end) begin
                    next_cur.st = fbparm_pkg::RX_DONE;
                end else if (byte_valid && !cur.stop
                             && cur.cnt < length) begin
                    // store field bytes from start
                    // at most length bytes, none for zero
                    next_cur.we = 1'b1;
                    next_cur.wd = byte_data;
                    next_cur.cnt = cur.cnt + 8'h01;
                    next_cur.addr = cur.addr + 8'h01;
                    // no wrap past ram end
                    if (cur.addr == `RAM_LAST_ADDR) next_cur.stop = 1'b1;
                end
            end
            fbparm_pkg::RX_DONE: begin
                next_cur.done = 1'b1;
                // sequence counters untouched in manual mode
                next_cur.adv = !manual;
                next_cur.st = fbparm_pkg::RX_IDLE;
            end
            default: next_cur.st = fbparm_pkg::RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
            cur.st <= fbparm_pkg::RX_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    assign ram_we = cur.we;
    assign ram_addr = cur.addr - 8'h01;
    assign ram_wdata = cur.wd;
    assign done = cur.done;
    assign count = cur.cnt;
    assign ctrl = cur.ctl;
    assign state_code = cur.st;
    assign seq_advance = cur.adv;

    a_count_bounded: assert property (@(posedge clk)
        disable iff (rst)
        ram_we |-> (count <= length))
        else $error("stored more bytes than buffer length");

    a_stop_holds: assert property (@(posedge clk)
        disable iff (rst)
        $past(cur.stop) |-> !ram_we)
        else $error("ram write after buffer end");
endmodule : rx_fill

// ==== core_model.sv ====
// core model: special function register reads and writes
// assumes: strobes change at falling edges of MCLK, one access at a time
`timescale 1ns/100ps
module core_model (
    // clock
    input  wire logic       MCLK,
    // register access
    output logic            SFR_WR,
    output logic            SFR_RD,
    output logic      [7:0] SFR_ADDR,
    output logic      [7:0] SFR_WDATA,
    input  wire logic [7:0] SFR_RDATA
);
    initial begin
        SFR_WR = 1'b0;
        SFR_RD = 1'b0;
        SFR_ADDR = 8'h00;
        SFR_WDATA = 8'h00;
    end
    // caller only writes while flags are idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge MCLK);
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WR = 1'b1;
        @(negedge MCLK);
        SFR_WR = 1'b0;
        SFR_ADDR = ~a;
        SFR_WDATA = ~d;
    endtask : wr
    // data stands one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge MCLK);
        SFR_ADDR = a;
        SFR_RD = 1'b1;
        @(negedge MCLK);
        d = SFR_RDATA;
        SFR_RD = 1'b0;
        SFR_ADDR = ~a;
    endtask : rd
endmodule : core_model

// ==== tb_top.sv ====
// testbench: register bank, receive fill and transmit handshake
// assumes: core_model issues register cycles at falling edges
`timescale 1ns/100ps
`include "fbparm_defs.svh"
module tb_top;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        sfr_wr, sfr_rd, rx_buffer_empty_flag, tx_buffer_full_flag, seq, ram_we;
    logic [7:0]  addr, wdata, rdata, tx_field, ram_addr, ram_wdata;
    logic [7:0]  rx_byte = 8'h00;
    logic        rbe_set = 0, tbf_set = 0, man = 0, bvalid = 0, fend = 0;
    logic        treq = 0, tdone = 0;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    int          err_total = 0, cmp_count = 0, seq_n = 0;
    always #12.5 mclk = ~mclk;
    core_model u_core (.MCLK(mclk), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
        .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_RDATA(rdata));
    fbparm_regs u_dut (.MCLK(mclk), .SRST(srst), .SFR_WR(sfr_wr),
        .SFR_RD(sfr_rd), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_RDATA(rdata), .RBE_SET(rbe_set), .TBF_SET(tbf_set),
        .RX_BUFFER_EMPTY_FLAG(rx_buffer_empty_flag), .TX_BUFFER_FULL_FLAG(tx_buffer_full_flag),
        .MANUAL_MODE(man), .RX_BYTE_VALID(bvalid), .RX_BYTE(rx_byte),
        .RX_FRAME_END(fend), .TX_CTRL_REQ(treq), .TX_FRAME_DONE(tdone),
        .TX_CTRL_FIELD(tx_field), .SEQ_ADVANCE(seq), .RAM_WE(ram_we),
        .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask : pulse
    // ram writes against the model queue
    always @(posedge mclk) begin
        if (ram_we === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
            chk(ram_addr, e[15:8]);
            chk(ram_wdata, e[7:0]);
        end
        if (seq === 1'b1) seq_n++;
    end
    task automatic frame(input int st, input int ln, input int n,
                         input logic m);
        logic [7:0] c, b, v;
        int cnt, s0, i;
        cnt = 0;
        s0 = seq_n;
        u_core.wr(`OFS_RX_BUFFER_START, 8'(st));
        u_core.wr(`OFS_RX_BUFFER_LENGTH, 8'(ln));
        man = m;
        pulse(rbe_set);
        repeat (3) @(negedge mclk);
        u_core.rd(`OFS_SERIAL_STATE_COUNTER, v);
        chk(v, 8'h01);
        c = 8'($urandom);
        rx_byte = c;
        pulse(bvalid);
        for (i = 0; i < n; i++) begin
            b = 8'($urandom);
            if (i < ln && st + i <= 191) begin
                exp_q.push_back({8'(st + i), b});
                cnt++;
            end
            rx_byte = b;
            @(negedge mclk);
            pulse(bvalid);
        end
        pulse(fend);
        for (i = 0; i < 20 && rx_buffer_empty_flag !== 1'b0; i++) @(negedge mclk);
        chk({7'h00, rx_buffer_empty_flag}, 8'h00);
        u_core.rd(`OFS_RX_FIELD_LENGTH, v);
        chk(v, 8'(cnt));
        u_core.rd(`OFS_RX_CONTROL_BYTE, v);
        chk(v, c);
        chk(8'(exp_q.size()), 8'h00);
        chk(8'(seq_n - s0), 8'(!m));
        $display("frame test done");
    endtask : frame
    initial begin
        logic [7:0] v, w;
        logic [7:0] ofs [7] = '{8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hDA,
                               8'hD9, 8'h55};
        void'($urandom(33214));
        repeat (3) @(negedge mclk);
        srst = 1'b0;
        foreach (ofs[i]) begin
            u_core.rd(ofs[i], v);
            chk(v, `REG_RESET);
        end
        $display("reset test done");
        foreach (ofs[i]) begin
            w = 8'($urandom);
            u_core.wr(ofs[i], w);
            u_core.rd(ofs[i], v);
            chk(v, (i == 0 || i > 4) ? 8'h00 : w);
        end
        $display("register test done");
        w = 8'($urandom);
        u_core.wr(`OFS_TX_CONTROL_BYTE, w);
        pulse(treq);
        chk(tx_field, 8'h00);
        man = 1'b1;
        pulse(treq);
        chk(tx_field, w);
        pulse(tbf_set);
        @(negedge mclk);
        chk({7'h00, tx_buffer_full_flag}, 8'h01);
        pulse(tdone);
        @(negedge mclk);
        chk({7'h00, tx_buffer_full_flag}, 8'h00);
        $display("transmit test done");
        frame(64, 5, 3, 1'b1);
        frame(128, 0, 2, 1'b0);
        frame(189, 8, 6, 1'b0);
        frame(16 + $urandom % 96, $urandom % 6, $urandom % 6, 1'($urandom));
        report_and_stop();
    end
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
endmodule : tb_top
